//--- src/amfs_pkg.sv
package amfs_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int RES_W = 12;
    localparam int CH_W = 3;
    localparam int SEQ_MAX = 4;
    localparam int IDX_W = 2;
    localparam int THR_W = 3;
    localparam int FIFO_DEPTH = 4;
    localparam int LCNT_W = 6;
    localparam int HOLD_W = 3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CMD_CLKS = 4;
    localparam int SAMPLE_CLKS = 12;
    localparam int T_CONV_NS = 1600;
    localparam int SCLK_TOP_NS = 50;
    localparam int CONV_CLKS = (T_CONV_NS + SCLK_TOP_NS - 1) / SCLK_TOP_NS;
    localparam int CLK_SYS_NS = 40;
    localparam int T_EOC_CS_NS = 100;
    localparam int EOC_CS_CYCLES = (T_EOC_CS_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [THR_W-1:0] RST_THR = 3'h4;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_REPEAT = 2'h1,
        MODE_SWEEP = 2'h2,
        MODE_RSWEEP = 2'h3
    } amfs_mode_t;

    typedef enum logic [2:0] {
        OP_CFG_WR = 3'h0,
        OP_CFG_RD = 3'h1,
        OP_SELECT = 3'h2,
        OP_CONVERT = 3'h3,
        OP_FIFO_RD = 3'h4,
        OP_PWR_DOWN = 3'h5
    } amfs_op_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_RUN = 2'b01,
        S_STORE = 2'b11,
        S_HOLD = 2'b10
    } amfs_sys_st_t;

    typedef enum logic [1:0] {
        L_IDLE = 2'b00,
        L_CMD = 2'b01,
        L_SAMPLE = 2'b11,
        L_CONV = 2'b10
    } amfs_link_st_t;

endpackage

//--- src/amfs_sync.sv
`timescale 1ns/1ps
module amfs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk) begin
        meta_reg <= d;
        q <= meta_reg;
    end
endmodule

//--- src/amfs_fifo.sv
`timescale 1ns/1ps
module amfs_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int LW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [LW-1:0] level_reg;
    logic push;
    logic pop;

    assign in_ready = (level_reg != LW'(DEPTH));
    assign out_valid = (level_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_reg[rd_ptr_reg];
    assign level = level_reg;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            level_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
            end
            if (push && !pop) begin
                level_reg <= level_reg + LW'(1);
            end else if (pop && !push) begin
                level_reg <= level_reg - LW'(1);
            end
        end
    end
endmodule

//--- src/amfs_top.sv
`timescale 1ns/1ps
module amfs_top #(
    parameter int DEPTH = amfs_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [2:0] cmd_op,
    input wire logic [1:0] cmd_mode,
    input wire logic [amfs_pkg::THR_W-1:0] cmd_threshold,
    input wire logic [amfs_pkg::CH_W-1:0] cmd_channel,
    input wire logic [amfs_pkg::SEQ_MAX*amfs_pkg::CH_W-1:0] cmd_seq,
    input wire logic conversion_start_pin,
    input wire logic [amfs_pkg::RES_W-1:0] adc_sample,
    output logic eoc,
    output logic powered_down,
    output logic [amfs_pkg::CH_W-1:0] mux_channel,
    output logic [amfs_pkg::RES_W-1:0] single_result,
    output logic single_valid,
    output logic [amfs_pkg::RES_W-1:0] fifo_rd_data,
    output logic fifo_rd_valid,
    output logic cmd_ignored,
    output logic cfg_rd_valid,
    output logic [1:0] cfg_mode_out,
    output logic [amfs_pkg::THR_W-1:0] cfg_threshold_out,
    output logic [amfs_pkg::THR_W-1:0] fill_level,
    output logic at_threshold
);
    import amfs_pkg::*;

    amfs_sys_st_t st_reg;
    amfs_link_st_t lst_reg;
    logic [HOLD_W-1:0] hold_reg;
    logic [1:0] mode_reg;
    logic [THR_W-1:0] thr_reg;
    logic [SEQ_MAX*CH_W-1:0] seq_reg;
    logic [CH_W-1:0] sel_chan_reg;
    logic chan_sel_reg;
    logic [IDX_W-1:0] seq_idx_reg;
    logic [THR_W-1:0] fill_reg;
    logic start_tgl_reg;
    logic kind_pd_reg;
    logic eoc_reg;
    logic pd_reg;
    logic pin_prev_reg;
    logic [CH_W-1:0] chan_active_reg;
    logic [RES_W-1:0] single_result_reg;
    logic single_valid_reg;
    logic [RES_W-1:0] rd_data_reg;
    logic rd_valid_reg;
    logic ignored_reg;
    logic cfg_rd_valid_reg;
    logic done_prev_reg;
    logic pin_q;
    logic done_q;
    logic acc;
    logic pin_trig;
    logic trig;
    logic at_thr;
    logic conv_ok;
    logic go;
    logic restart;
    logic pd_go;
    logic cfg_wr;
    logic done_edge;
    logic last_of_batch;
    logic fifo_push;
    logic fifo_pop;
    logic fifo_flush;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [RES_W-1:0] fifo_out_data;
    logic [$clog2(DEPTH+1)-1:0] fifo_level;
    logic [CH_W-1:0] go_chan;
    // link domain
    logic rst_link;
    logic start_q;
    logic start_seen_reg;
    logic [LCNT_W-1:0] lcnt_reg;
    logic lpd_reg;
    logic done_tgl_reg;
    logic [RES_W-1:0] lresult_reg;
    logic [RES_W-1:0] sample_q;
    logic [LCNT_W-1:0] ast_samp_reg;
    logic [LCNT_W-1:0] ast_conv_reg;

    // ------------------------------------------------------------
    // crossings
    // ------------------------------------------------------------
    amfs_sync #(.WIDTH(1)) u_pin_sync (.clk(clk_sys), .d(conversion_start_pin), .q(pin_q));
    amfs_sync #(.WIDTH(1)) u_done_sync (.clk(clk_sys), .d(done_tgl_reg), .q(done_q));
    amfs_sync #(.WIDTH(1)) u_rst_sync (.clk(clk_link), .d(rst), .q(rst_link));
    amfs_sync #(.WIDTH(1)) u_start_sync (.clk(clk_link), .d(start_tgl_reg), .q(start_q));
    amfs_sync #(.WIDTH(RES_W)) u_sample_sync (.clk(clk_link), .d(adc_sample), .q(sample_q));

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    assign pin_trig = pin_q && !pin_prev_reg && (st_reg == S_IDLE);
    assign cmd_ready = (st_reg == S_IDLE) && !pin_trig;
    assign acc = cmd_valid && cmd_ready;
    assign trig = pin_trig || (acc && cmd_op == OP_CONVERT);
    assign cfg_wr = acc && cmd_op == OP_CFG_WR;
    assign pd_go = acc && cmd_op == OP_PWR_DOWN;
    assign fifo_pop = acc && cmd_op == OP_FIFO_RD && fifo_out_valid;
    assign at_thr = (fill_reg == thr_reg);
    assign done_edge = done_q != done_prev_reg;
    assign last_of_batch = (fill_reg + THR_W'(1)) == thr_reg;

    always_comb begin
        conv_ok = 1'b0;
        restart = 1'b0;
        unique case (mode_reg)
            MODE_SINGLE: conv_ok = chan_sel_reg;
            MODE_REPEAT: conv_ok = chan_sel_reg && !at_thr && fifo_in_ready;
            MODE_SWEEP: conv_ok = !at_thr && fifo_in_ready;
            MODE_RSWEEP: begin
                conv_ok = 1'b1;
                restart = at_thr;
            end
        endcase
    end

    assign go = trig && conv_ok;
    assign go_chan = (mode_reg[1] == 1'b0) ? sel_chan_reg :
                     restart ? seq_reg[CH_W-1:0] : seq_reg[seq_idx_reg*CH_W +: CH_W];

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= S_IDLE;
            hold_reg <= '0;
        end else begin
            unique case (st_reg)
                S_IDLE: begin
                    if (go || pd_go) begin
                        st_reg <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (done_edge) begin
                        st_reg <= S_STORE;
                    end
                end
                S_STORE: begin
                    st_reg <= S_HOLD;
                    hold_reg <= '0;
                end
                S_HOLD: begin
                    hold_reg <= hold_reg + HOLD_W'(1);
                    if (hold_reg == HOLD_W'(EOC_CS_CYCLES - 1)) begin
                        st_reg <= S_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            start_tgl_reg <= 1'b0;
            kind_pd_reg <= 1'b0;
            chan_active_reg <= '0;
            eoc_reg <= 1'b1;
            pin_prev_reg <= 1'b0;
            done_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= pin_q;
            done_prev_reg <= done_q;
            if (go || pd_go) begin
                start_tgl_reg <= !start_tgl_reg;
                kind_pd_reg <= pd_go;
                eoc_reg <= 1'b0;
            end else if (st_reg == S_STORE) begin
                eoc_reg <= 1'b1;
            end
            if (go) begin
                chan_active_reg <= go_chan;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration and channel selection
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_reg <= RST_MODE;
            thr_reg <= RST_THR;
            seq_reg <= '0;
        end else if (cfg_wr) begin
            mode_reg <= cmd_mode;
            thr_reg <= cmd_threshold;
            seq_reg <= cmd_seq;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || cfg_wr) begin
            chan_sel_reg <= 1'b0;
            sel_chan_reg <= (rst) ? '0 : sel_chan_reg;
        end else if (acc && cmd_op == OP_SELECT) begin
            chan_sel_reg <= 1'b1;
            sel_chan_reg <= cmd_channel;
        end else if (st_reg == S_STORE && !kind_pd_reg && mode_reg == MODE_REPEAT && last_of_batch) begin
            chan_sel_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || cfg_wr || (go && restart)) begin
            seq_idx_reg <= '0;
        end else if (st_reg == S_STORE && !kind_pd_reg && mode_reg[1]) begin
            seq_idx_reg <= last_of_batch ? '0 : seq_idx_reg + IDX_W'(1);
        end
    end

    // ------------------------------------------------------------
    // result store
    // ------------------------------------------------------------
    assign fifo_flush = cfg_wr || (go && restart);
    assign fifo_push = (st_reg == S_STORE) && !kind_pd_reg && (mode_reg != MODE_SINGLE);

    amfs_fifo #(.WIDTH(RES_W), .DEPTH(DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .flush(fifo_flush),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(lresult_reg),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    always_ff @(posedge clk_sys) begin
        if (rst || fifo_flush) begin
            fill_reg <= '0;
        end else if (fifo_push) begin
            fill_reg <= fill_reg + THR_W'(1);
        end else if (fifo_pop) begin
            fill_reg <= fill_reg - THR_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            single_result_reg <= '0;
            single_valid_reg <= 1'b0;
            rd_data_reg <= '0;
            rd_valid_reg <= 1'b0;
            ignored_reg <= 1'b0;
            cfg_rd_valid_reg <= 1'b0;
        end else begin
            single_valid_reg <= (st_reg == S_STORE) && !kind_pd_reg && (mode_reg == MODE_SINGLE);
            if ((st_reg == S_STORE) && !kind_pd_reg && (mode_reg == MODE_SINGLE)) begin
                single_result_reg <= lresult_reg;
            end
            rd_valid_reg <= fifo_pop;
            if (fifo_pop) begin
                rd_data_reg <= fifo_out_data;
            end
            ignored_reg <= (trig && !conv_ok) || (acc && cmd_op == OP_FIFO_RD && !fifo_out_valid);
            cfg_rd_valid_reg <= acc && cmd_op == OP_CFG_RD;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pd_reg <= 1'b0;
        end else if (st_reg == S_STORE && kind_pd_reg) begin
            pd_reg <= 1'b1;
        end else if (go || (acc && cmd_op != OP_PWR_DOWN)) begin
            pd_reg <= 1'b0;
        end
    end

    assign eoc = eoc_reg;
    assign powered_down = pd_reg;
    assign mux_channel = chan_active_reg;
    assign single_result = single_result_reg;
    assign single_valid = single_valid_reg;
    assign fifo_rd_data = rd_data_reg;
    assign fifo_rd_valid = rd_valid_reg;
    assign cmd_ignored = ignored_reg;
    assign cfg_rd_valid = cfg_rd_valid_reg;
    assign cfg_mode_out = mode_reg;
    assign cfg_threshold_out = thr_reg;
    assign fill_level = fill_reg;
    assign at_threshold = at_thr;

    // ------------------------------------------------------------
    // link side: command, sampling and conversion phases
    // ------------------------------------------------------------
    always_ff @(posedge clk_link) begin
        if (rst_link) begin
            lst_reg <= L_IDLE;
            lcnt_reg <= '0;
            start_seen_reg <= 1'b0;
            lpd_reg <= 1'b0;
        end else begin
            lcnt_reg <= lcnt_reg + LCNT_W'(1);
            unique case (lst_reg)
                L_IDLE: begin
                    lcnt_reg <= '0;
                    if (start_q != start_seen_reg) begin
                        start_seen_reg <= start_q;
                        lpd_reg <= kind_pd_reg;
                        lst_reg <= L_CMD;
                    end
                end
                L_CMD: begin
                    if (lcnt_reg == LCNT_W'(CMD_CLKS - 1)) begin
                        lcnt_reg <= '0;
                        lst_reg <= lpd_reg ? L_IDLE : L_SAMPLE;
                    end
                end
                L_SAMPLE: begin
                    if (lcnt_reg == LCNT_W'(SAMPLE_CLKS - 1)) begin
                        lcnt_reg <= '0;
                        lst_reg <= L_CONV;
                    end
                end
                L_CONV: begin
                    if (lcnt_reg == LCNT_W'(CONV_CLKS - 1)) begin
                        lst_reg <= L_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_link) begin
        if (rst_link) begin
            done_tgl_reg <= 1'b0;
            lresult_reg <= '0;
        end else begin
            if (lst_reg == L_SAMPLE && lcnt_reg == LCNT_W'(SAMPLE_CLKS - 1)) begin
                lresult_reg <= sample_q;
            end
            if ((lst_reg == L_CONV && lcnt_reg == LCNT_W'(CONV_CLKS - 1)) ||
                (lst_reg == L_CMD && lpd_reg && lcnt_reg == LCNT_W'(CMD_CLKS - 1))) begin
                done_tgl_reg <= !done_tgl_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    always_ff @(posedge clk_link) begin
        ast_samp_reg <= (lst_reg == L_SAMPLE) ? ast_samp_reg + LCNT_W'(1) : '0;
        ast_conv_reg <= (lst_reg == L_CONV) ? ast_conv_reg + LCNT_W'(1) : '0;
    end

    sequence seq_cmd_phase;
        (lst_reg == L_CMD) [*4] ##1 (lst_reg != L_CMD);
    endsequence

    sequence seq_sample_exit;
        (lst_reg == L_SAMPLE) ##1 (lst_reg == L_CONV);
    endsequence

    sequence seq_conv_exit;
        (lst_reg == L_CONV) ##1 (lst_reg == L_IDLE);
    endsequence

    AST_CMD_PHASE: assert property (@(posedge clk_link) disable iff (rst_link)
        $rose(lst_reg == L_CMD) |-> seq_cmd_phase)
        else $error("command phase not four link clocks");
    AST_SAMPLE_LEN: assert property (@(posedge clk_link) disable iff (rst_link)
        seq_sample_exit |-> $past(ast_samp_reg) == LCNT_W'(SAMPLE_CLKS - 1))
        else $error("sampling phase length wrong");
    AST_CONV_LEN: assert property (@(posedge clk_link) disable iff (rst_link)
        seq_conv_exit |-> $past(ast_conv_reg) == LCNT_W'(CONV_CLKS - 1))
        else $error("conversion phase length wrong");
    AST_SWEEP_IGNORE: assert property (@(posedge clk_sys) disable iff (rst)
        trig && mode_reg == MODE_SWEEP && at_thr |-> ##1 ignored_reg && st_reg == S_IDLE && $stable(fill_reg))
        else $error("sweep at threshold ran a conversion");
    AST_RSWEEP_RESTART: assert property (@(posedge clk_sys) disable iff (rst)
        trig && mode_reg == MODE_RSWEEP && at_thr |-> ##1 fill_reg == '0 && st_reg == S_RUN
            && chan_active_reg == seq_reg[CH_W-1:0])
        else $error("repeat sweep did not restart");
    AST_CHAN_NEEDED: assert property (@(posedge clk_sys) disable iff (rst)
        trig && !mode_reg[1] && !chan_sel_reg |-> ##1 ignored_reg && st_reg == S_IDLE)
        else $error("conversion without channel select");
    AST_SINGLE_BYPASS: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg == S_STORE && !kind_pd_reg && mode_reg == MODE_SINGLE |-> !fifo_push ##1 single_valid_reg)
        else $error("single shot result mishandled");
    AST_FILL_MATCH: assert property (@(posedge clk_sys) disable iff (rst)
        fill_reg == THR_W'(fifo_level) and (fifo_flush |=> fill_reg == '0))
        else $error("fill counter out of step");
    AST_SEQ_REWIND: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg == S_STORE && !kind_pd_reg && mode_reg[1] && last_of_batch |=> seq_idx_reg == '0 && at_thr)
        else $error("sweep index not rewound");
    AST_PD_CYCLE: assert property (@(posedge clk_sys) disable iff (rst)
        pd_go |-> ##[3:40] pd_reg)
        else $error("power-down cycle did not complete");
endmodule

//--- verification/amfs_host.sv
`timescale 1ns/1ps
module amfs_host (
    input wire logic clk_sys,
    input wire logic cmd_ready,
    input wire logic cmd_ignored,
    input wire logic fifo_rd_valid,
    input wire logic [amfs_pkg::CH_W-1:0] mux_channel,
    output logic cmd_valid,
    output logic [2:0] cmd_op,
    output logic [1:0] cmd_mode,
    output logic [amfs_pkg::THR_W-1:0] cmd_threshold,
    output logic [amfs_pkg::CH_W-1:0] cmd_channel,
    output logic [amfs_pkg::SEQ_MAX*amfs_pkg::CH_W-1:0] cmd_seq,
    output logic [amfs_pkg::RES_W-1:0] adc_sample
);
    import amfs_pkg::*;
    logic ign_seen;
    logic rdv_seen;
    logic timed_out;
    // analog source: each input reads as 150h plus its own channel number
    assign adc_sample = {9'h02A, mux_channel};
    initial begin
        cmd_valid = 1'b0;
        cmd_op = 3'h0;
        cmd_mode = 2'h0;
        cmd_channel = 3'h0;
        cmd_threshold = 3'h4;
        cmd_seq = {3'h4, 3'h3, 3'h2, 3'h1};
    end
    task automatic send(input logic [2:0] op, input logic [1:0] md, input logic [CH_W-1:0] ch);
        int n;
        @(negedge clk_sys);
        cmd_op = op;
        cmd_mode = md;
        cmd_channel = ch;
        cmd_valid = 1'b1;
        timed_out = 1'b0;
        n = 0;
        // ready comes from registers only, so the value seen here holds at the next rising edge
        while (cmd_ready !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 400) timed_out = 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        ign_seen = cmd_ignored;
        rdv_seen = fifo_rd_valid;
        n = 0;
        // next command only once ready again after end of conversion
        while (cmd_ready !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 400) timed_out = 1'b1;
    endtask
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
    import amfs_pkg::*;
    logic clk_sys = 0, clk_link = 0, rst = 1, cmd_valid, cmd_ready, eoc, powered_down;
    logic single_valid, fifo_rd_valid, cmd_ignored, cfg_rd_valid, at_threshold;
    logic [2:0] cmd_op;
    logic [1:0] cmd_mode, cfg_mode_out;
    logic [THR_W-1:0] cmd_threshold, cfg_threshold_out, fill_level;
    logic [CH_W-1:0] cmd_channel, mux_channel;
    logic [SEQ_MAX*CH_W-1:0] cmd_seq;
    logic [RES_W-1:0] adc_sample, single_result, fifo_rd_data;
    int fail_count = 0, n_tests = 0, cycles = 0;
    int n_single = 0, n_cfgrd = 0;
    logic start_pin = 1'b0;
    initial forever #20 clk_sys = ~clk_sys;
    initial forever #3 clk_link = ~clk_link;
    amfs_top u_amfs_top (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_mode(cmd_mode), .cmd_threshold(cmd_threshold),
        .cmd_channel(cmd_channel), .cmd_seq(cmd_seq), .conversion_start_pin(start_pin), .adc_sample(adc_sample),
        .eoc(eoc), .powered_down(powered_down), .mux_channel(mux_channel), .single_result(single_result),
        .single_valid(single_valid), .fifo_rd_data(fifo_rd_data), .fifo_rd_valid(fifo_rd_valid),
        .cmd_ignored(cmd_ignored), .cfg_rd_valid(cfg_rd_valid), .cfg_mode_out(cfg_mode_out),
        .cfg_threshold_out(cfg_threshold_out), .fill_level(fill_level), .at_threshold(at_threshold));
    amfs_host u_amfs_host (.clk_sys(clk_sys), .cmd_ready(cmd_ready), .cmd_ignored(cmd_ignored),
        .fifo_rd_valid(fifo_rd_valid), .mux_channel(mux_channel), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_mode(cmd_mode), .cmd_threshold(cmd_threshold), .cmd_channel(cmd_channel), .cmd_seq(cmd_seq),
        .adc_sample(adc_sample));
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic op(input logic [2:0] o, input logic [1:0] md = 2'h0, input logic [2:0] ch = 3'h0);
        u_amfs_host.send(o, md, ch);
        if (u_amfs_host.timed_out === 1'b1) begin
            fail_count++;
            finish_test();
        end
    endtask
    task automatic t_repeat();
        op(OP_CFG_WR, MODE_REPEAT);
        op(OP_CONVERT);
        check("ign_nosel", 16'(u_amfs_host.ign_seen), 16'h1);
        op(OP_SELECT, 2'h0, 3'h5);
        repeat (4) op(OP_CONVERT);
        check("fill", 16'(fill_level), 16'h4);
        check("at_thr", 16'(at_threshold), 16'h1);
        op(OP_CONVERT);
        check("ign_resel", 16'(u_amfs_host.ign_seen), 16'h1);
        op(OP_SELECT, 2'h0, 3'h5);
        op(OP_CONVERT);
        check("ign_full", 16'(u_amfs_host.ign_seen), 16'h1);
        repeat (4) begin
            op(OP_FIFO_RD);
            check("rdv", 16'(u_amfs_host.rdv_seen), 16'h1);
            check("rdd", 16'(fifo_rd_data), 16'h155);
        end
        check("fill0", 16'(fill_level), 16'h0);
        op(OP_CONVERT);
        check("ign_again", 16'(u_amfs_host.ign_seen), 16'h0);
        check("mux_again", 16'(mux_channel), 16'h5);
        check("fill1", 16'(fill_level), 16'h1);
    endtask
    task automatic t_sweep(input logic [1:0] md);
        op(OP_CFG_WR, md);
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 4; i++) begin
                op(OP_CONVERT);
                check("mux", 16'(mux_channel), 16'(i + 1));
            end
            check("fill", 16'(fill_level), 16'h4);
            if (md == MODE_SWEEP) begin
                op(OP_CONVERT);
                check("ign_thr", 16'(u_amfs_host.ign_seen), 16'h1);
            end
            for (int i = 0; i < 4; i++) begin
                op(OP_FIFO_RD);
                check("rdd", 16'(fifo_rd_data), 16'(12'h151 + i));
            end
        end
        if (md == MODE_RSWEEP) begin
            repeat (4) op(OP_CONVERT);
            op(OP_CONVERT);
            check("ign_rs", 16'(u_amfs_host.ign_seen), 16'h0);
            check("fill_rs", 16'(fill_level), 16'h1);
            check("mux_rs", 16'(mux_channel), 16'h1);
        end
    endtask
    task automatic t_single();
        int n = 0;
        op(OP_CFG_WR, MODE_SINGLE);
        op(OP_CFG_RD);
        @(posedge clk_sys);
        check("cfg_rd", 16'(n_cfgrd), 16'h1);
        check("cfg_mode", 16'(cfg_mode_out), 16'(MODE_SINGLE));
        check("cfg_thr", 16'(cfg_threshold_out), 16'h4);
        op(OP_SELECT, 2'h0, 3'h6);
        op(OP_CONVERT);
        check("single", 16'(single_result), 16'h156);
        check("single_v", 16'(n_single), 16'h1);
        check("fill_s", 16'(fill_level), 16'h0);
        op(OP_PWR_DOWN);
        check("pdn", 16'(powered_down), 16'h1);
        check("eoc", 16'(eoc), 16'h1);
        // conversion started from the pin instead of the command port
        @(negedge clk_sys);
        start_pin = 1'b1;
        repeat (3) @(negedge clk_sys);
        check("eoc_low", 16'(eoc), 16'h0);
        start_pin = 1'b0;
        while (cmd_ready !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 400) begin
            fail_count++;
            finish_test();
        end
        check("pin_conv", 16'(n_single), 16'h2);
        check("pin_mux", 16'(mux_channel), 16'h6);
        check("pdn_wake", 16'(powered_down), 16'h0);
    endtask
    // one-cycle pulses, counted where they stand
    always @(negedge clk_sys) begin
        if (single_valid === 1'b1) n_single++;
        if (cfg_rd_valid === 1'b1) n_cfgrd++;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        t_repeat();
        t_sweep(MODE_SWEEP);
        t_sweep(MODE_RSWEEP);
        t_single();
        finish_test();
    end
endmodule
